// [verilog/spm_map.vh]
`ifndef SPM_MAP_VH
`define SPM_MAP_VH
`define SPM_DATA_W      16
`define SPM_LEN_W       12
`define SPM_LEN_DEF     12'h0020
`define SPM_GAIN_W      4
`define SPM_GAIN_DEF    4'h0
`define SPM_CTRL_W      16
`define SPM_CTRL_LEN_LO 0
`define SPM_CTRL_GN_LO  12
`define SPM_ST_IDLE     2'h0
`define SPM_ST_RUN      2'h1
`define SPM_ST_W        2
`endif

// [verilog/spm_ctrl_slot.v]
`timescale 1ns/1ps
`default_nettype none
`include "spm_map.vh"
// one-entry control holding slot; ready while empty
module spm_ctrl_slot #(
  parameter W = `SPM_CTRL_W
) (
  // clock and reset
  input  wire         i_ref_clk,
  input  wire         i_sys_rst,
  // control stream in
  input  wire [W-1:0] i_ctl_tdata,
  input  wire         i_ctl_tvalid,
  output wire         o_ctl_tready,
  // slot out
  output reg  [W-1:0] o_word,
  output wire         o_full,
  input  wire         i_take
);
  reg full_reg;
  assign o_ctl_tready = ~full_reg | i_take;
  assign o_full       = full_reg;
  always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      full_reg <= 1'b0;
      o_word   <= {W{1'b0}};
    end else begin
      if (i_ctl_tvalid && o_ctl_tready) begin
        full_reg <= 1'b1;
        o_word   <= i_ctl_tdata;
      end else if (i_take) begin
        full_reg <= 1'b0;
      end
    end
  end
endmodule // spm_ctrl_slot
`default_nettype wire

// [verilog/spm_bound_chk.v]
`timescale 1ns/1ps
`default_nettype none
`include "spm_map.vh"
// compares incoming last flag with internal packet end; events are one-cycle pulses
module spm_bound_chk #(
  parameter LW = `SPM_LEN_W
) (
  // clock and reset
  input  wire          i_ref_clk,
  input  wire          i_sys_rst,
  // accepted beat
  input  wire          i_beat,
  input  wire          i_last,
  input  wire [LW-1:0] i_len,
  input  wire          i_restart,
  // position
  output wire          o_at_end,
  output reg  [LW-1:0] o_pos,
  // events
  output reg           o_evt_miss,
  output reg           o_evt_unexp
);
  assign o_at_end = (o_pos == i_len - {{(LW-1){1'b0}}, 1'b1});
  always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_pos       <= {LW{1'b0}};
      o_evt_miss  <= 1'b0;
      o_evt_unexp <= 1'b0;
    end else begin
      // condition is registered for this cycle's accepted beat only, low without a beat
      o_evt_miss  <= i_beat & o_at_end & ~i_last;
      o_evt_unexp <= i_beat & ~o_at_end & i_last;
      if (i_restart) begin
        o_pos <= {LW{1'b0}};
      end else if (i_beat) begin
        // count wraps on internal end, last flag ignored
        o_pos <= o_at_end ? {LW{1'b0}} : o_pos + {{(LW-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // spm_bound_chk
`default_nettype wire

// [verilog/spm_core.v]
`timescale 1ns/1ps
`default_nettype none
`include "spm_map.vh"
// packet processing front end: passes data unscaled with a control gain on tuser, frames by
// internal length, reports boundary mismatches as valid-only events
module spm_core #(
  parameter DW = `SPM_DATA_W,
  parameter LW = `SPM_LEN_W,
  parameter GW = `SPM_GAIN_W,
  parameter CW = `SPM_CTRL_W
) (
  // clock and reset
  input  wire          i_ref_clk,
  input  wire          i_sys_rst,
  // mode strap: 1 blocking control channel
  input  wire          i_ctl_blocking,
  // control stream slave
  input  wire [CW-1:0] i_ctl_tdata,
  input  wire          i_ctl_tvalid,
  output wire          o_ctl_tready,
  // data stream slave
  input  wire [DW-1:0] i_dat_tdata,
  input  wire          i_dat_tvalid,
  input  wire          i_dat_tlast,
  output wire          o_dat_tready,
  // data stream master
  output reg  [DW-1:0] o_res_tdata,
  output reg  [GW-1:0] o_res_tuser,
  output reg           o_res_tvalid,
  output reg           o_res_tlast,
  input  wire          i_res_tready,
  // events
  output wire          o_evt_miss_last,
  output wire          o_evt_unexp_last
);
  localparam [LW-1:0] LEN_DEF  = `SPM_LEN_DEF;
  localparam [GW-1:0] GAIN_DEF = `SPM_GAIN_DEF;
  localparam [`SPM_ST_W-1:0] ST_IDLE = `SPM_ST_IDLE;
  localparam [`SPM_ST_W-1:0] ST_RUN  = `SPM_ST_RUN;

  reg [`SPM_ST_W-1:0] st_reg;
  reg [`SPM_ST_W-1:0] st_next;
  reg [LW-1:0]        len_reg;
  reg [GW-1:0]        gain_reg;
  wire [CW-1:0]       slot_word;
  wire                slot_full;
  wire                at_end;
  wire                in_idle;
  wire                out_free;
  wire                beat;
  wire                take;
  wire [LW-1:0]       slot_len;
  wire [GW-1:0]       slot_gain;

  assign slot_len  = slot_word[`SPM_CTRL_LEN_LO +: LW];
  assign slot_gain = slot_word[`SPM_CTRL_GN_LO +: GW];
  assign out_free  = ~o_res_tvalid | i_res_tready;

  assign in_idle = (st_reg == ST_IDLE);
  // blocking consumes its word only with the packet's first beat, so a
  // word is never spent without data; non-blocking loads in an idle gap
  assign take = in_idle &
                (i_ctl_blocking ? beat :
                                  (slot_full & ~i_dat_tvalid));
  wire can_start = i_ctl_blocking ? slot_full : 1'b1;
  wire running   = (st_reg == ST_RUN) | (in_idle & can_start);
  assign o_dat_tready = running & out_free;
  assign beat = i_dat_tvalid & o_dat_tready;

  // settings used for a packet: blocking loads from slot at start
  wire [LW-1:0] eff_len = (in_idle && i_ctl_blocking) ? slot_len : len_reg;
  wire [LW-1:0] use_len = (eff_len == {LW{1'b0}}) ? LEN_DEF : eff_len;

  always @* begin
    st_next = st_reg;
    case (st_reg)
      ST_IDLE: begin
        if (beat && !at_end) begin
          st_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (beat && at_end) begin
          st_next = ST_IDLE;
        end
      end
      default: begin
        st_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      st_reg       <= ST_IDLE;
      len_reg      <= LEN_DEF;
      gain_reg     <= GAIN_DEF;
      o_res_tdata  <= {DW{1'b0}};
      o_res_tuser  <= {GW{1'b0}};
      o_res_tvalid <= 1'b0;
      o_res_tlast  <= 1'b0;
    end else begin
      st_reg <= st_next;
      if (take) begin
        len_reg  <= slot_len;
        gain_reg <= slot_gain;
      end
      if (beat) begin
        o_res_tdata  <= i_dat_tdata;  // unscaled data
        o_res_tuser  <= (take ? slot_gain : gain_reg);  // exponent only
        o_res_tvalid <= 1'b1;
        o_res_tlast  <= at_end;  // one output packet per internal packet
      end else if (i_res_tready) begin
        o_res_tvalid <= 1'b0;
      end
    end
  end

  spm_ctrl_slot #(
    .W (CW)
  ) u_slot (
    .i_ref_clk    (i_ref_clk),
    .i_sys_rst    (i_sys_rst),
    .i_ctl_tdata  (i_ctl_tdata),
    .i_ctl_tvalid (i_ctl_tvalid),
    .o_ctl_tready (o_ctl_tready),
    .o_word       (slot_word),
    .o_full       (slot_full),
    .i_take       (take)
  );

  spm_bound_chk #(
    .LW (LW)
  ) u_chk (
    .i_ref_clk   (i_ref_clk),
    .i_sys_rst   (i_sys_rst),
    .i_beat      (beat),
    .i_last      (i_dat_tlast),
    .i_len       (use_len),
    .i_restart   (in_idle & ~beat),
    .o_at_end    (at_end),
    .o_pos       (),
    .o_evt_miss  (o_evt_miss_last),
    .o_evt_unexp (o_evt_unexp_last)
  );
endmodule // spm_core
`default_nettype wire

// [tb/spm_core_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module spm_core_sva (
  input wire logic        i_ref_clk,
  input wire logic        i_sys_rst,
  input wire logic [15:0] i_dat_tdata,
  input wire logic        i_dat_tvalid,
  input wire logic        i_dat_tlast,
  input wire logic        o_dat_tready,
  input wire logic [15:0] o_res_tdata,
  input wire logic        o_res_tvalid,
  input wire logic        o_res_tlast,
  input wire logic        i_res_tready,
  input wire logic        o_evt_miss_last,
  input wire logic        o_evt_unexp_last
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  wire logic b = i_dat_tvalid && o_dat_tready;
  wire logic st = o_res_tvalid && !i_res_tready;
  a_miss_cause: assert property (b |=> o_evt_miss_last == (o_res_tlast && !$past(i_dat_tlast)))
    else $error("bad miss event");
  a_unexp_cause: assert property (b |=> o_evt_unexp_last == (!o_res_tlast && $past(i_dat_tlast)))
    else $error("bad unexp event");
  a_evt_idle: assert property (!b |=> !o_evt_miss_last && !o_evt_unexp_last)
    else $error("event held");
  a_res_copy: assert property (b |=> o_res_tvalid && o_res_tdata == $past(i_dat_tdata))
    else $error("bad result");
  a_res_hold: assert property (st |=> o_res_tvalid && $stable(o_res_tdata))
    else $error("result dropped");
  a_full_stall: assert property (st |-> !o_dat_tready)
    else $error("ready while full");
  a_evt_excl: assert property (o_evt_miss_last |-> !o_evt_unexp_last)
    else $error("both events");
  a_rst_quiet: assert property (disable iff (1'b0) i_sys_rst |=> !o_res_tvalid && !o_evt_miss_last)
    else $error("active after reset");
  c_miss: cover property (o_evt_miss_last);
  c_unexp: cover property (o_evt_unexp_last);
  c_stall: cover property (st);
endmodule // spm_core_sva
bind spm_core spm_core_sva chk (.i_ref_clk, .i_sys_rst, .i_dat_tdata, .i_dat_tvalid,
  .i_dat_tlast, .o_dat_tready, .o_res_tdata, .o_res_tvalid, .o_res_tlast, .i_res_tready,
  .o_evt_miss_last, .o_evt_unexp_last);
`default_nettype wire

// [tb/spm_src.sv]
`timescale 1ns/1ps
`default_nettype none
// upstream master: control and data streams, released lines show inverse
module spm_src (
  input  wire logic        i_ref_clk,
  output logic [15:0] o_cd,
  output logic        o_cv,
  input  wire logic        i_cr,
  output logic [15:0] o_dd,
  output logic        o_dv,
  output logic        o_dl,
  input  wire logic        i_dr
);
  initial {o_cd, o_cv, o_dd, o_dv, o_dl} = '0;
  task automatic ctl(input logic [15:0] w);
    @(negedge i_ref_clk);
    o_cd = w;
    o_cv = 1'b1;
    #1;
    while (!i_cr) @(negedge i_ref_clk) #1;
    @(negedge i_ref_clk);
    o_cv = 1'b0;
    o_cd = ~w;
  endtask
  task automatic pkt(input int n, input int lp, input logic [15:0] b);
    for (int k = 0; k < n; k++) begin
      @(negedge i_ref_clk);
      o_dd = b + k[15:0];
      o_dl = (k == lp);
      o_dv = 1'b1;
      #1;
      while (!i_dr) @(negedge i_ref_clk) #1;
    end
    @(negedge i_ref_clk);
    o_dv = 1'b0;
    o_dl = ~o_dl;
    o_dd = ~o_dd;
  endtask
endmodule // spm_src
`default_nettype wire

// [tb/test_stream_packet_event_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module test_stream_packet_event_monitor;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        blk = 1'b1;
  logic        rr = 1'b1;
  wire  [15:0] cd, dd, rd;
  wire  [3:0]  ru;
  wire         cv, cr, dv, dl, dr, rv, rl, ms, ux;
  logic [20:0] q[$];
  int          mismatches, n_tests, cyc, nm, nu;
  always #20 clk = ~clk;
  spm_src src (.i_ref_clk(clk), .o_cd(cd), .o_cv(cv), .i_cr(cr), .o_dd(dd), .o_dv(dv),
    .o_dl(dl), .i_dr(dr));
  spm_core uut (.i_ref_clk(clk), .i_sys_rst(rst), .i_ctl_blocking(blk), .i_ctl_tdata(cd),
    .i_ctl_tvalid(cv), .o_ctl_tready(cr), .i_dat_tdata(dd), .i_dat_tvalid(dv),
    .i_dat_tlast(dl), .o_dat_tready(dr), .o_res_tdata(rd), .o_res_tuser(ru),
    .o_res_tvalid(rv), .o_res_tlast(rl), .i_res_tready(rr), .o_evt_miss_last(ms),
    .o_evt_unexp_last(ux));
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      mismatches++;
      tally_and_finish();
    end
    if (!rst && rv === 1'b1 && rr) q.push_back({rl, ru, rd});
    if (ms === 1'b1) nm++;
    if (ux === 1'b1) nu++;
  end
  task automatic chk(input logic [20:0] g, e);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // drain, then compare one output packet and the event counts
  task automatic exp(input int n, input logic [3:0] g, input logic [15:0] b, input int m, u);
    repeat (6) @(negedge clk);
    for (int k = 0; k < n; k++) chk(q.pop_front(), {k == n - 1, g, b + k[15:0]});
    chk(21'(nm), 21'(m));
    chk(21'(nu), 21'(u));
  endtask
  task automatic t_block; // blocking waits for control, then one packet per word
    fork
      src.pkt(2, 5, 16'h0100);
      begin
        repeat (5) @(negedge clk);
        chk(21'(q.size()), 21'h0);
        src.ctl(16'h3002);
      end
    join
    exp(2, 4'h3, 16'h0100, 1, 0);
    $display("t_block done");
  endtask
  task automatic t_group; // one long packet spans two internal ones, output stalls
    fork
      src.pkt(4, 3, 16'h0200);
      begin
        src.ctl(16'h5002);
        src.ctl(16'h5002);
      end
      repeat (9) @(negedge clk) rr = ~rr;
    join
    rr = 1'b1;
    exp(2, 4'h5, 16'h0200, 2, 0);
    exp(2, 4'h5, 16'h0202, 2, 0);
    $display("t_group done");
  endtask
  task automatic t_nonblk; // settings reused, then replaced
    blk = 1'b0;
    src.pkt(2, 0, 16'h0300);
    exp(2, 4'h5, 16'h0300, 3, 1);
    src.ctl(16'h7003);
    src.pkt(3, 2, 16'h0400);
    exp(3, 4'h7, 16'h0400, 3, 1);
    $display("t_nonblk done");
  endtask
  task automatic t_reset; // defaults return: length 32, gain 0
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    src.pkt(32, 31, 16'h0500);
    exp(32, 4'h0, 16'h0500, 3, 1);
    $display("t_reset done");
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    t_block();
    t_group();
    t_nonblk();
    t_reset();
    tally_and_finish();
  end
endmodule // test_stream_packet_event_monitor
`default_nettype wire
